// ---- rtl/fifo_byte_count.sv ----
// byte occupancy counter of one fifo with refusal reporting
`timescale 1ns/1ns
`default_nettype none
module fifo_byte_count (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // count control
  input  wire logic        clear,
  input  wire logic        add,
  input  wire logic [2:0]  add_bytes,
  input  wire logic        sub,
  input  wire logic [2:0]  sub_bytes,
  // status
  output logic [15:0] count,
  output logic        full,
  output logic        empty,
  output logic        add_refused,
  output logic        sub_refused
);
  typedef struct packed {
    logic [15:0] count;
  } cnt_state_type;

  cnt_state_type st;
  cnt_state_type next_st;
  logic [15:0]   add_n;
  logic [15:0]   sub_n;

  // refuse what would pass full or go below empty
  always_comb
  begin
    next_st = st;
    add_n = {13'h0000, add_bytes};
    sub_n = {13'h0000, sub_bytes};
    add_refused = add && (st.count > spi_stat_pkg::FIFO_DEPTH - add_n);
    sub_refused = sub && (st.count < sub_n);
    if (add && !add_refused)
      next_st.count = next_st.count + add_n;
    if (sub && !sub_refused)
      next_st.count = next_st.count - sub_n;
    if (clear)
      next_st.count = 16'h0000;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign count = st.count;
  assign full  = (st.count == spi_stat_pkg::FIFO_DEPTH);
  assign empty = (st.count == 16'h0000);
endmodule
`default_nettype wire

// ---- rtl/spi_stat_pkg.sv ----
// constants and carrier types for the spi status and interrupt block
package spi_stat_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_COUNTS = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;
  localparam logic [7:0] OFS_THRESH = 8'h1C;
  // status bit positions
  localparam int BIT_XFER_DONE = 0;
  localparam int BIT_DMA_DONE  = 1;
  localparam int BIT_TX_ERR    = 2;
  localparam int BIT_RX_ERR    = 3;
  localparam int BIT_PROG_ERR  = 4;
  localparam int BIT_TX_FULL   = 8;
  localparam int BIT_TX_EMPTY  = 9;
  localparam int BIT_TX_REQ    = 10;
  localparam int BIT_TX_STALL  = 11;
  localparam int BIT_RX_FULL   = 12;
  localparam int BIT_RX_EMPTY  = 13;
  localparam int BIT_RX_REQ    = 14;
  localparam int BIT_RX_STALL  = 15;
  localparam int BIT_BUSY      = 16;
  localparam int DESC_LSB      = 24;
  // field widths
  localparam int COUNT_W = 16;
  localparam int DESC_W  = 4;
  // reset values and masks
  localparam logic [31:0] IRQ_EN_RESET = 32'h0000_2000;
  localparam logic [31:0] IRQ_EN_MASK  = 32'h0000_771F;
  localparam logic [31:0] STICKY_MASK  = 32'h0000_CC1F;
  localparam logic [31:0] THRESH_RESET = 32'h0000_0000;
  localparam logic [3:0]  DESC_RESET   = 4'h0;
  // fifo depth in bytes
  localparam logic [15:0] FIFO_DEPTH = 16'h0020;

  // classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_type;

  // one-cycle events from ports, shift engine, dma and execute register
  typedef struct packed {
    logic       tx_push;
    logic [2:0] tx_push_bytes;
    logic       rx_pop;
    logic [2:0] rx_pop_bytes;
    logic       rx_store;
    logic       tx_fetch;
    logic       byte_done;
    logic       length_hit;
    logic       tx_dma_done;
    logic       rx_dma_done;
    logic       desc_done;
    logic       exec_start;
    logic       exec_stop;
    logic       exec_clear;
  } eng_evt_type;

  // live configuration of the active transfer
  typedef struct packed {
    logic [1:0] if_mode;
    logic [1:0] tx_xfer_en;
    logic       rx_xfer_en;
    logic [1:0] tx_dma_en;
    logic [1:0] rx_dma_en;
    logic       desc_en;
    logic       close_en;
    logic       desc_last;
    logic [3:0] desc_first;
    logic [3:0] desc_next;
  } cfg_type;
endpackage

// ---- rtl/spi_status_irq.sv ----
// status, byte counts, interrupt enables and thresholds of the spi master
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - status shows active descriptor buffer index
// - busy flag while transfer executes
// - sticky stall on store into full rx
// - rx request while count at or above threshold
// - live rx empty and full, empty resets one
// - sticky stall on fetch from empty tx
// - tx request while count at or below threshold
// - live tx empty and full, both reset zero
// - flag illegal start/stop or mode setup
// - flag rx read with too little data
// - flag tx write into full fifo
// - dma done flag on dma done signal
// - every enabled dma direction done before flagging
// - close enabled: dma and transfer done together
// - dma done fires on every descriptor
// - manual mode: done at transfer length
// - dma mode: transfer done with dma done
// - descriptor mode: done on last descriptor
// - stop: done after current byte completes
// - rx and tx byte counts readable
// - enable bit per event except tx and rx stall, rx empty set
// - thresholds; zero disables the request
// - stop halts at next byte boundary
// - port reads/writes move the byte counts
module spi_status_irq (
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      arst_n,
  // wishbone slave
  input  wire spi_stat_pkg::wb_req_type  wb_req,
  output logic [31:0]                    wb_dat_o,
  output logic                           wb_ack_o,
  // engine, port, dma and execute events
  input  wire spi_stat_pkg::eng_evt_type evt,
  input  wire spi_stat_pkg::cfg_type     cfg,
  // interrupt and engine control
  output logic                           irq,
  output logic                           stop_hold
);
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [31:0] irq_en;
    logic [31:0] thresh;
    logic        busy;
    logic [3:0]  desc_idx;
    logic        tx_armed;
    logic        tx_dma_seen;
    logic        rx_dma_seen;
    logic        stop_pend;
    logic        irq;
  } top_state_type;

  top_state_type st;
  top_state_type next_st;

  logic [15:0] tx_count;
  logic [15:0] rx_count;
  logic        tx_full;
  logic        tx_empty_cnt;
  logic        rx_full;
  logic        rx_empty;
  logic        tx_ovf;
  logic        tx_starve;
  logic        rx_over;
  logic        rx_unf;
  logic [31:0] flag_set;
  logic [31:0] flag_clr;
  logic [31:0] flags;
  logic [31:0] status_word;
  logic [31:0] byte_en;
  logic        bus_req;
  logic        wr_take;
  logic        dma_on;
  logic        tx_seen_n;
  logic        rx_seen_n;
  logic        dma_all;
  logic        start_ok;
  logic        prog_err;
  logic        xfer_set;
  logic        stop_done;
  logic        rx_req_cond;
  logic        tx_req_cond;

  // transmit fifo count: port writes add, engine fetches remove
  fifo_byte_count u_tx_count (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .clear       (evt.exec_clear),
    .add         (evt.tx_push),
    .add_bytes   (evt.tx_push_bytes),
    .sub         (evt.tx_fetch),
    .sub_bytes   (3'h1),
    .count       (tx_count),
    .full        (tx_full),
    .empty       (tx_empty_cnt),
    .add_refused (tx_ovf),
    .sub_refused (tx_starve)
  );

  // receive fifo count: engine stores add, port reads remove
  fifo_byte_count u_rx_count (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .clear       (evt.exec_clear),
    .add         (evt.rx_store),
    .add_bytes   (3'h1),
    .sub         (evt.rx_pop),
    .sub_bytes   (evt.rx_pop_bytes),
    .count       (rx_count),
    .full        (rx_full),
    .empty       (rx_empty),
    .add_refused (rx_over),
    .sub_refused (rx_unf)
  );

  // sticky status flags
  sticky_flags #(
    .W (32)
  ) u_flags (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .set     (flag_set),
    .clr     (flag_clr),
    .flags   (flags)
  );

  // byte lanes of a bus write
  assign byte_en = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}},
                    {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
  assign bus_req = wb_req.cyc && wb_req.stb;
  assign wr_take = bus_req && wb_req.we && st.ack;

  // request levels against thresholds, zero threshold disables
  assign rx_req_cond = (st.thresh[31:16] != 16'h0000)
                       && (rx_count >= st.thresh[31:16]);
  assign tx_req_cond = (st.thresh[15:0] != 16'h0000)
                       && (tx_count <= st.thresh[15:0]);

  // dma completion, both active directions gathered
  assign dma_on    = (cfg.tx_dma_en != 2'h0) || (cfg.rx_dma_en != 2'h0);
  assign tx_seen_n = st.tx_dma_seen || evt.tx_dma_done;
  assign rx_seen_n = st.rx_dma_seen || evt.rx_dma_done;
  assign dma_all   = dma_on && (evt.tx_dma_done || evt.rx_dma_done)
                     && ((cfg.tx_dma_en == 2'h0) || tx_seen_n)
                     && ((cfg.rx_dma_en == 2'h0) || rx_seen_n);

  // illegal execute or mode setup
  assign prog_err = (evt.exec_start && evt.exec_stop)
                    || (evt.exec_start && (cfg.if_mode != 2'h0)
                        && (cfg.tx_xfer_en != 2'h0) && cfg.rx_xfer_en)
                    || (evt.exec_start && (cfg.if_mode == 2'h3));
  assign start_ok = evt.exec_start && !prog_err;

  // transfer completion by mode
  assign stop_done = st.stop_pend && evt.byte_done;
  always_comb
  begin
    if (cfg.desc_en)
      xfer_set = (evt.desc_done && cfg.desc_last) || (dma_all && cfg.close_en);
    else if (dma_on)
      xfer_set = dma_all;
    else
      xfer_set = evt.length_hit;
    xfer_set = xfer_set || stop_done;
  end

  // setting events of the sticky flags
  always_comb
  begin
    flag_set = '0;
    flag_set[spi_stat_pkg::BIT_RX_STALL]  = rx_over;
    flag_set[spi_stat_pkg::BIT_RX_REQ]    = rx_req_cond;
    flag_set[spi_stat_pkg::BIT_TX_STALL]  = tx_starve;
    flag_set[spi_stat_pkg::BIT_TX_REQ]    = tx_req_cond;
    flag_set[spi_stat_pkg::BIT_PROG_ERR]  = prog_err;
    flag_set[spi_stat_pkg::BIT_RX_ERR]    = rx_unf;
    flag_set[spi_stat_pkg::BIT_TX_ERR]    = tx_ovf;
    flag_set[spi_stat_pkg::BIT_DMA_DONE]  = dma_all;
    flag_set[spi_stat_pkg::BIT_XFER_DONE] = xfer_set;
  end

  // write one to status clears, at the acknowledged edge only
  assign flag_clr = (wr_take && (wb_req.adr == spi_stat_pkg::OFS_STATUS))
                    ? (wb_req.dat & byte_en & spi_stat_pkg::STICKY_MASK)
                    : 32'h0000_0000;

  // status word with live bits
  always_comb
  begin
    status_word = flags & spi_stat_pkg::STICKY_MASK;
    status_word[spi_stat_pkg::BIT_RX_EMPTY] = rx_empty;
    status_word[spi_stat_pkg::BIT_RX_FULL]  = rx_full;
    status_word[spi_stat_pkg::BIT_TX_EMPTY] = st.tx_armed && tx_empty_cnt;
    status_word[spi_stat_pkg::BIT_TX_FULL]  = tx_full;
    status_word[spi_stat_pkg::BIT_BUSY]     = st.busy;
    status_word[spi_stat_pkg::DESC_LSB +: spi_stat_pkg::DESC_W] = st.desc_idx;
  end

  // next state: bus slave, control state and interrupt
  always_comb
  begin
    next_st = st;
    next_st.ack = bus_req && !st.ack;
    next_st.rdata = 32'h0000_0000;
    if (bus_req && !st.ack && !wb_req.we)
    begin
      unique case (wb_req.adr)
        spi_stat_pkg::OFS_STATUS: next_st.rdata = status_word;
        spi_stat_pkg::OFS_COUNTS: next_st.rdata = {rx_count, tx_count};
        spi_stat_pkg::OFS_IRQ_EN: next_st.rdata = st.irq_en;
        spi_stat_pkg::OFS_THRESH: next_st.rdata = st.thresh;
        default:                  next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_take && (wb_req.adr == spi_stat_pkg::OFS_IRQ_EN))
      next_st.irq_en = ((st.irq_en & ~byte_en) | (wb_req.dat & byte_en))
                       & spi_stat_pkg::IRQ_EN_MASK;
    if (wr_take && (wb_req.adr == spi_stat_pkg::OFS_THRESH))
      next_st.thresh = (st.thresh & ~byte_en) | (wb_req.dat & byte_en);
    // dma done gathering
    next_st.tx_dma_seen = tx_seen_n && !dma_all;
    next_st.rx_dma_seen = rx_seen_n && !dma_all;
    if (start_ok)
    begin
      next_st.tx_dma_seen = 1'b0;
      next_st.rx_dma_seen = 1'b0;
    end
    // busy and active descriptor
    if (xfer_set)
      next_st.busy = 1'b0;
    if (start_ok)
      next_st.busy = 1'b1;
    if (start_ok && cfg.desc_en)
      next_st.desc_idx = cfg.desc_first;
    else if (evt.desc_done && !cfg.desc_last)
      next_st.desc_idx = cfg.desc_next;
    // stop holds the engine until the byte boundary
    if (evt.exec_stop && !evt.exec_start && st.busy)
      next_st.stop_pend = 1'b1;
    if (stop_done || !next_st.busy)
      next_st.stop_pend = 1'b0;
    if (evt.tx_push || evt.exec_clear)
      next_st.tx_armed = 1'b1;
    next_st.irq = |(status_word & st.irq_en);
  end

  // state register
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st          <= '0;
      st.irq_en   <= spi_stat_pkg::IRQ_EN_RESET;
      st.thresh   <= spi_stat_pkg::THRESH_RESET;
      st.desc_idx <= spi_stat_pkg::DESC_RESET;
    end
    else
      st <= next_st;
  end

  assign wb_dat_o  = st.rdata;
  assign wb_ack_o  = st.ack;
  assign irq       = st.irq;
  assign stop_hold = st.stop_pend;

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_stop_req;
    evt.exec_stop && !evt.exec_start && st.busy;
  endsequence
  sequence s_boundary;
    evt.byte_done;
  endsequence
  sequence s_bus_read;
    bus_req && !wb_req.we && !st.ack;
  endsequence

  AST_STOP_DONE: assert property ((stop_hold and s_boundary) |=> flags[0] && !st.busy)
    else $error("stop at byte boundary did not complete transfer");
  AST_STOP_HOLD: assert property (s_stop_req |=> stop_hold)
    else $error("stop request not held toward engine");
  AST_COUNT_READ: assert property ((s_bus_read and (wb_req.adr == spi_stat_pkg::OFS_COUNTS))
      |=> wb_ack_o && wb_dat_o == {$past(rx_count), $past(tx_count)})
    else $error("count register read wrong");
  // skip the first edge after release, where the previous cycle was still in reset
  AST_IRQ: assert property ($past(arst_n) |-> irq == |($past(status_word) & $past(st.irq_en)))
    else $error("irq not the or of enabled flags");
  AST_RX_REQ: assert property (rx_req_cond |=> flags[14])
    else $error("rx request flag missing");
  AST_TX_REQ: assert property (tx_req_cond |=> flags[10])
    else $error("tx request flag missing");
  AST_TX_OVF: assert property (evt.tx_push && tx_full |=> flags[2])
    else $error("tx overflow not flagged");
  AST_RX_UNF: assert property (evt.rx_pop && rx_empty |=> flags[3])
    else $error("rx underflow not flagged");
  AST_PROG: assert property (evt.exec_start && evt.exec_stop |=> flags[4] && !$rose(st.busy))
    else $error("start with stop not flagged");
  AST_CLOSE: assert property (dma_all && cfg.close_en |=> flags[1] && flags[0])
    else $error("dma and transfer done not together");
  AST_SET_WINS: assert property (flag_set[0] && flag_clr[0] |=> flags[0])
    else $error("clear beat a setting event");
  AST_SET_WINS_REQ: assert property (flag_set[10] && flag_clr[10] |=> flags[10])
    else $error("clear beat a held request condition");
  AST_BUSY: assert property (start_ok && !xfer_set |=> st.busy)
    else $error("busy not raised on start");
endmodule
`default_nettype wire

// ---- rtl/sticky_flags.sv ----
// write-one-to-clear sticky flags where a set beats a clear
`timescale 1ns/1ns
`default_nettype none
module sticky_flags #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  // set and clear vectors
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // flags
  output logic [W-1:0] flags
);
  typedef struct packed {
    logic [W-1:0] flags;
  } flag_state_type;

  flag_state_type st;
  flag_state_type next_st;

  // set wins over clear
  always_comb
  begin
    next_st.flags = (st.flags & ~clr) | set;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign flags = st.flags;
endmodule
`default_nettype wire

// ---- tb/spi_far_model.sv ----
// far-side model: shift engine and dma channel event pulses
`timescale 1ns/1ns
`default_nettype none
module spi_far_model (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  // command from the bench
  input  wire logic                 go,
  input  wire logic [2:0]           op,
  // engine-side events
  output spi_stat_pkg::eng_evt_type evt_o
);
  integer                    seed = 32'h203A;
  integer                    dly;
  spi_stat_pkg::eng_evt_type e;
  // one pulse per command, after zero to three idle cycles
  always
  begin
    @(posedge sys_clk);
    if (!arst_n)
      evt_o <= '0;
    else if (go)
    begin
      dly = $random(seed) & 3;
      e = '0;
      case (op)
        3'h0: e.rx_store = 1'b1;
        3'h1: e.tx_fetch = 1'b1;
        3'h2: e.byte_done = 1'b1;
        3'h3: e.length_hit = 1'b1;
        3'h4: e.tx_dma_done = 1'b1;
        3'h5: e.rx_dma_done = 1'b1;
        default: e.desc_done = 1'b1;
      endcase
      repeat (dly) @(posedge sys_clk);
      evt_o <= e;
      @(posedge sys_clk);
      evt_o <= '0;
    end
  end
endmodule
`default_nettype wire

// ---- tb/spi_status_irq_tb.sv ----
// self-checking bench of the spi status and interrupt block
`timescale 1ns/1ns
`default_nettype none
module spi_status_irq_tb;
  logic                      sys_clk = 1'b0;
  logic                      arst_n = 1'b0;
  spi_stat_pkg::wb_req_type  wb_req = '0;
  spi_stat_pkg::eng_evt_type tb_evt = '0;
  spi_stat_pkg::eng_evt_type far_evt;
  spi_stat_pkg::cfg_type     cfg = '0;
  logic [31:0]               wb_dat_o;
  logic                      wb_ack_o;
  logic                      irq;
  logic                      stop_hold;
  logic                      go = 1'b0;
  logic [2:0]                op = 3'h0;
  logic [31:0]               exp_q[$];
  logic [31:0]               msk_q[$];
  logic [31:0]               rnd;
  integer                    seed = 32'h203A;
  integer                    fails = 0;
  integer                    n_tests = 0;
  integer                    k;
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  spi_status_irq dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .evt(spi_stat_pkg::eng_evt_type'(tb_evt | far_evt)), .cfg(cfg), .irq(irq),
    .stop_hold(stop_hold));
  spi_far_model far_u (.sys_clk(sys_clk), .arst_n(arst_n), .go(go), .op(op),
    .evt_o(far_evt));
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one classic wishbone cycle, bounded wait for ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    wb_req <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'hF, dat:dat};
    for (i = 0; i < 20; i++)
    begin
      @(posedge sys_clk);
      if (wb_ack_o === 1'b1)
        break;
    end
    wb_req <= '0;
    @(posedge sys_clk);
    if (i == 20)
    begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] msk);
    exp_q.push_back(exp & msk);
    msk_q.push_back(msk);
    wb(1'b0, adr, 32'h0);
  endtask
  task automatic st(input logic [31:0] exp, input logic [31:0] msk);
    rd(spi_stat_pkg::OFS_STATUS, exp, msk);
  endtask
  // port or execute pulse, then let the status register settle
  task automatic pulse(input spi_stat_pkg::eng_evt_type e);
    tb_evt <= e;
    @(posedge sys_clk);
    tb_evt <= '0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic far(input logic [2:0] o);
    op <= o;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (7) @(posedge sys_clk);
  endtask
  // read data watcher takes the oldest note at each read ack
  always @(posedge sys_clk)
    if (wb_ack_o === 1'b1 && wb_req.cyc === 1'b1 && wb_req.we === 1'b0 && exp_q.size() > 0)
      check("read data", wb_dat_o & msk_q.pop_front(), exp_q.pop_front());
  // main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("irq", {31'h0, irq}, 32'h1);
    st(32'h0000_2000, 32'hFFFF_FFFF);
    rd(spi_stat_pkg::OFS_COUNTS, 32'h0, 32'hFFFF_FFFF);
    rd(spi_stat_pkg::OFS_IRQ_EN, spi_stat_pkg::IRQ_EN_RESET, 32'hFFFF_FFFF);
    rd(spi_stat_pkg::OFS_THRESH, spi_stat_pkg::THRESH_RESET, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0, 32'hFFFF_FFFF);
    rnd = $random(seed);
    wb(1'b1, spi_stat_pkg::OFS_IRQ_EN, rnd);
    rd(spi_stat_pkg::OFS_IRQ_EN, rnd & spi_stat_pkg::IRQ_EN_MASK, 32'hFFFF_FFFF);
    wb(1'b1, spi_stat_pkg::OFS_THRESH, rnd);
    rd(spi_stat_pkg::OFS_THRESH, rnd, 32'hFFFF_FFFF);
    wb(1'b1, spi_stat_pkg::OFS_IRQ_EN, 32'h0000_0004);
    wb(1'b1, spi_stat_pkg::OFS_THRESH, 32'h0002_0020);
    check("irq", {31'h0, irq}, 32'h0);
    // fill the transmit side until it refuses
    for (k = 0; k < 8; k++)
      pulse('{tx_push:1'b1, tx_push_bytes:3'h4, default:'0});
    rd(spi_stat_pkg::OFS_COUNTS, 32'h0000_0020, 32'hFFFF_FFFF);
    st(32'h0000_0500, 32'h0000_0704);
    pulse('{tx_push:1'b1, tx_push_bytes:3'h1, default:'0});
    rd(spi_stat_pkg::OFS_COUNTS, 32'h0000_0020, 32'hFFFF_FFFF);
    st(32'h0000_0004, 32'h0000_0004);
    check("irq", {31'h0, irq}, 32'h1);
    wb(1'b1, spi_stat_pkg::OFS_STATUS, 32'h0000_0404);
    st(32'h0000_0400, 32'h0000_0404);
    check("irq", {31'h0, irq}, 32'h0);
    far(3'h1);
    rd(spi_stat_pkg::OFS_COUNTS, 32'h0000_001F, 32'hFFFF_FFFF);
    pulse('{exec_clear:1'b1, default:'0});
    st(32'h0000_2200, 32'h0000_3300);
    far(3'h1);
    st(32'h0000_0800, 32'h0000_0800);
    // receive side: request, underflow, full and stall
    for (k = 0; k < 3; k++)
      far(3'h0);
    rd(spi_stat_pkg::OFS_COUNTS, 32'h0003_0000, 32'hFFFF_FFFF);
    st(32'h0000_4000, 32'h0000_7000);
    pulse('{rx_pop:1'b1, rx_pop_bytes:3'h4, default:'0});
    rd(spi_stat_pkg::OFS_COUNTS, 32'h0003_0000, 32'hFFFF_FFFF);
    st(32'h0000_0008, 32'h0000_0008);
    for (k = 3; k < 32; k++)
      far(3'h0);
    st(32'h0000_1000, 32'h0000_9000);
    far(3'h0);
    st(32'h0000_8000, 32'h0000_8000);
    // illegal start requests, including start with stop
    pulse('{exec_start:1'b1, exec_stop:1'b1, default:'0});
    st(32'h0000_0010, 32'h0001_0010);
    for (k = 1; k < 4; k++)
    begin
      wb(1'b1, spi_stat_pkg::OFS_STATUS, 32'h0000_0010);
      cfg <= '{if_mode:k[1:0], tx_xfer_en:2'h1, rx_xfer_en:1'b1, default:'0};
      pulse('{exec_start:1'b1, default:'0});
      st(32'h0000_0010, 32'h0001_0010);
    end
    // manual transfer, then a stopped one
    cfg <= '0;
    pulse('{exec_start:1'b1, default:'0});
    st(32'h0001_0000, 32'h0001_0001);
    far(3'h3);
    st(32'h0000_0001, 32'h0001_0001);
    wb(1'b1, spi_stat_pkg::OFS_STATUS, 32'h0000_0001);
    pulse('{exec_start:1'b1, default:'0});
    pulse('{exec_stop:1'b1, default:'0});
    check("stop hold", {31'h0, stop_hold}, 32'h1);
    st(32'h0001_0000, 32'h0001_0001);
    far(3'h2);
    st(32'h0000_0001, 32'h0001_0001);
    check("stop hold", {31'h0, stop_hold}, 32'h0);
    // both dma directions
    wb(1'b1, spi_stat_pkg::OFS_STATUS, 32'h0000_0003);
    cfg <= '{tx_xfer_en:2'h1, rx_xfer_en:1'b1, tx_dma_en:2'h1, rx_dma_en:2'h1, close_en:1'b1,
             default:'0};
    pulse('{exec_start:1'b1, default:'0});
    far(3'h4);
    st(32'h0, 32'h0000_0003);
    far(3'h5);
    st(32'h0000_0003, 32'h0000_0003);
    // descriptor chain of two
    wb(1'b1, spi_stat_pkg::OFS_STATUS, 32'h0000_0003);
    cfg <= '{desc_en:1'b1, desc_first:4'h3, desc_next:4'h5, default:'0};
    pulse('{exec_start:1'b1, default:'0});
    st(32'h0300_0000, 32'h0F00_0001);
    far(3'h6);
    st(32'h0500_0000, 32'h0F00_0001);
    cfg.desc_last <= 1'b1;
    far(3'h6);
    st(32'h0000_0001, 32'h0000_0001);
    report_and_stop();
  end
endmodule
`default_nettype wire
